//--- logic/bsfu_top.sv
// bit, shift and flag unit: working byte, source byte and status flags behind AXI4-Lite
// assumes one AXI4-Lite master on clk_i; a command write executes in the edge that takes it
//
// How it works
// - rotate left through carry: c into bit 0, bit 7 to c, flags z c n v.
// - rotate right through carry: c into bit 7, bit 0 to c, flags z c n v.
// - arithmetic shift right keeps bit 7, bits 0..6 from above, flags z c n v.
// - nibble swap exchanges low and high halves, no flag changes.
// - indexed status flag forced to one or zero, only that bit changes.
// - selected source bit copied into the transfer flag only.
// - transfer flag written into the selected working byte bit, flags kept.
// - carry set or cleared alone in one clock.
// - negative set or cleared alone in one clock.
// - zero set or cleared alone in one clock.
// - global interrupt enable set or cleared alone in one clock.
// - signed flag set or cleared alone in one clock.
`include "bsfu_map.svh"

module bsfu_top #(
    parameter int ADDR_W = 8
) (
    input  logic                  clk_i,
    input  logic                  arst_n_i,
    // write address channel
    input  logic [ADDR_W-1:0]     s_axi_awaddr_i,
    input  logic [2:0]            s_axi_awprot_i,
    input  logic                  s_axi_awvalid_i,
    output logic                  s_axi_awready_o,
    // write data channel
    input  logic [31:0]           s_axi_wdata_i,
    input  logic [3:0]            s_axi_wstrb_i,
    input  logic                  s_axi_wvalid_i,
    output logic                  s_axi_wready_o,
    // write response channel
    output bsfu_pkg::bsfu_resp_t  s_axi_bresp_o,
    output logic                  s_axi_bvalid_o,
    input  logic                  s_axi_bready_i,
    // read address channel
    input  logic [ADDR_W-1:0]     s_axi_araddr_i,
    input  logic [2:0]            s_axi_arprot_i,
    input  logic                  s_axi_arvalid_i,
    output logic                  s_axi_arready_o,
    // read data channel
    output logic [31:0]           s_axi_rdata_o,
    output bsfu_pkg::bsfu_resp_t  s_axi_rresp_o,
    output logic                  s_axi_rvalid_o,
    input  logic                  s_axi_rready_i,
    // state seen by the surrounding core
    output bsfu_pkg::bsfu_byte_t  dest_o,
    output bsfu_pkg::bsfu_byte_t  flags_o
);
    import bsfu_pkg::*;

    // ----------
    // address decode
    // ----------
    typedef enum logic [2:0] {
        SEL_DEST,
        SEL_SRC,
        SEL_FLAGS,
        SEL_CMD,
        SEL_STAT,
        SEL_NONE
    } bsfu_sel_e;

    // shared by the read and the write path; low two bits are ignored
    function automatic bsfu_sel_e addr_sel(input logic [ADDR_W-1:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'h0};
        if (w == `BSFU_ADDR_DEST) begin
            return SEL_DEST;
        end else if (w == `BSFU_ADDR_SRC) begin
            return SEL_SRC;
        end else if (w == `BSFU_ADDR_FLAGS) begin
            return SEL_FLAGS;
        end else if (w == `BSFU_ADDR_CMD) begin
            return SEL_CMD;
        end else if (w == `BSFU_ADDR_STAT) begin
            return SEL_STAT;
        end else begin
            return SEL_NONE;
        end
    endfunction

    // ----------
    // state
    // ----------
    logic                 awready_r;
    logic                 wready_r;
    logic                 bvalid_r;
    bsfu_resp_t           bresp_r;
    logic                 arready_r;
    logic                 rvalid_r;
    logic [31:0]          rdata_r;
    bsfu_resp_t           rresp_r;
    logic                 aw_full_r;
    logic                 w_full_r;
    logic [ADDR_W-1:0]    awaddr_r;
    logic [31:0]          wdata_r;
    logic [3:0]           wstrb_r;
    bsfu_byte_t           dest_r;
    bsfu_byte_t           src_r;
    bsfu_byte_t           flags_r;
    bsfu_byte_t           cmd_r;
    bsfu_byte_t           cnt_r;
    logic                 bad_r;

    // ----------
    // write channel handshakes
    // ----------
    logic                 aw_take;
    logic                 w_take;
    logic                 aw_have;
    logic                 w_have;
    logic                 do_write;
    logic                 bvalid_nxt;
    logic                 aw_full_nxt;
    logic                 w_full_nxt;
    logic                 awready_nxt;
    logic                 wready_nxt;
    logic [ADDR_W-1:0]    wr_addr;
    logic [31:0]          wr_data;
    logic [3:0]           wr_strb;
    bsfu_sel_e            wr_sel;
    logic                 wr_lane0;

    // address and data are taken in either order and held until both are in
    assign aw_take     = s_axi_awvalid_i & awready_r;
    assign w_take      = s_axi_wvalid_i & wready_r;
    assign aw_have     = aw_full_r | aw_take;
    assign w_have      = w_full_r | w_take;
    assign do_write    = aw_have & w_have & ~bvalid_r;
    assign bvalid_nxt  = do_write | (bvalid_r & ~s_axi_bready_i);
    assign aw_full_nxt = aw_have & ~do_write;
    assign w_full_nxt  = w_have & ~do_write;
    assign awready_nxt = ~aw_full_nxt & ~bvalid_nxt;
    assign wready_nxt  = ~w_full_nxt & ~bvalid_nxt;
    assign wr_addr     = aw_full_r ? awaddr_r : s_axi_awaddr_i;
    assign wr_data     = w_full_r ? wdata_r : s_axi_wdata_i;
    assign wr_strb     = w_full_r ? wstrb_r : s_axi_wstrb_i;
    assign wr_sel      = addr_sel(wr_addr);
    // every writable register lives in byte lane 0; other lanes are dropped
    assign wr_lane0    = do_write & wr_strb[0];

    // ----------
    // read channel handshakes
    // ----------
    logic                 ar_take;
    logic                 rvalid_nxt;
    logic                 arready_nxt;
    bsfu_sel_e            rd_sel;
    logic [31:0]          rd_word;

    assign ar_take     = s_axi_arvalid_i & arready_r;
    assign rvalid_nxt  = ar_take | (rvalid_r & ~s_axi_rready_i);
    assign arready_nxt = ~rvalid_nxt;
    assign rd_sel      = addr_sel(s_axi_araddr_i);

    always_comb begin
        rd_word = `BSFU_RST_WORD;
        unique case (rd_sel)
            SEL_DEST:  rd_word[7:0] = dest_r;
            SEL_SRC:   rd_word[7:0] = src_r;
            SEL_FLAGS: rd_word[7:0] = flags_r;
            SEL_CMD:   rd_word[7:0] = cmd_r;
            SEL_STAT: begin
                rd_word[7:0]           = cnt_r;
                rd_word[`BSFU_STAT_BAD] = bad_r;
            end
            SEL_NONE:  rd_word = `BSFU_RST_WORD;
        endcase
    end

    // ----------
    // command execution
    // ----------
    logic                 exec_go;
    bsfu_op_e             exec_op;
    bsfu_idx_t            exec_idx;
    bsfu_byte_t           exec_dest;
    bsfu_byte_t           exec_flags;
    logic                 exec_bad;
    bsfu_byte_t           dest_nxt;
    bsfu_byte_t           src_nxt;
    bsfu_byte_t           flags_nxt;
    bsfu_byte_t           cmd_nxt;
    bsfu_byte_t           cnt_nxt;
    logic                 bad_nxt;

    // op in bits 4..0, index in bits 7..5
    assign exec_go  = wr_lane0 & (wr_sel == SEL_CMD);
    assign exec_op  = bsfu_op_e'(wr_data[`BSFU_CMD_OP_MSB:`BSFU_CMD_OP_LSB]);
    assign exec_idx = wr_data[`BSFU_CMD_IDX_MSB:`BSFU_CMD_IDX_LSB];

    bsfu_exec u_exec (
        .op_i    (exec_op),
        .idx_i   (exec_idx),
        .dest_i  (dest_r),
        .src_i   (src_r),
        .flags_i (flags_r),
        .dest_o  (exec_dest),
        .flags_o (exec_flags),
        .bad_o   (exec_bad)
    );

    // single-edge result commit, covers every op
    assign dest_nxt  = exec_go ? exec_dest :
                       (wr_lane0 & (wr_sel == SEL_DEST)) ? wr_data[7:0] : dest_r;
    assign src_nxt   = (wr_lane0 & (wr_sel == SEL_SRC)) ? wr_data[7:0] : src_r;
    // flags written back whole, executor touches only its bits
    assign flags_nxt = exec_go ? exec_flags :
                       (wr_lane0 & (wr_sel == SEL_FLAGS)) ? wr_data[7:0] : flags_r;
    assign cmd_nxt   = exec_go ? wr_data[7:0] : cmd_r;
    // count of commands taken, wraps; lets software see that a command landed
    assign cnt_nxt   = exec_go ? cnt_r + `BSFU_CNT_STEP : cnt_r;
    assign bad_nxt   = exec_go ? exec_bad : bad_r;

    // ----------
    // write path registers
    // ----------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            bvalid_r  <= 1'b0;
            aw_full_r <= 1'b0;
            w_full_r  <= 1'b0;
        end else begin
            awready_r <= awready_nxt;
            wready_r  <= wready_nxt;
            bvalid_r  <= bvalid_nxt;
            aw_full_r <= aw_full_nxt;
            w_full_r  <= w_full_nxt;
        end
    end

    // payload holders; reset keeps them defined though they are only read when full
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            awaddr_r <= '0;
            wdata_r  <= `BSFU_RST_WORD;
            wstrb_r  <= 4'h0;
            bresp_r  <= `BSFU_RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_r <= s_axi_awaddr_i;
            end
            if (w_take) begin
                wdata_r <= s_axi_wdata_i;
                wstrb_r <= s_axi_wstrb_i;
            end
            if (do_write) begin
                bresp_r <= (wr_sel == SEL_NONE) ? `BSFU_RESP_SLVERR : `BSFU_RESP_OKAY;
            end
        end
    end

    // ----------
    // read path registers
    // ----------
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= `BSFU_RST_WORD;
            rresp_r   <= `BSFU_RESP_OKAY;
        end else begin
            arready_r <= arready_nxt;
            rvalid_r  <= rvalid_nxt;
            if (ar_take) begin
                rdata_r <= rd_word;
                rresp_r <= (rd_sel == SEL_NONE) ? `BSFU_RESP_SLVERR : `BSFU_RESP_OKAY;
            end
        end
    end

    // ----------
    // datapath registers
    // ----------
    // flag ops land in the same edge as the command write
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            dest_r  <= `BSFU_RST_BYTE;
            src_r   <= `BSFU_RST_BYTE;
            flags_r <= `BSFU_RST_BYTE;
            cmd_r   <= `BSFU_RST_BYTE;
            cnt_r   <= `BSFU_RST_BYTE;
            bad_r   <= 1'b0;
        end else begin
            dest_r  <= dest_nxt;
            src_r   <= src_nxt;
            flags_r <= flags_nxt;
            cmd_r   <= cmd_nxt;
            cnt_r   <= cnt_nxt;
            bad_r   <= bad_nxt;
        end
    end

    // ----------
    // outputs
    // ----------
    assign s_axi_awready_o = awready_r;
    assign s_axi_wready_o  = wready_r;
    assign s_axi_bvalid_o  = bvalid_r;
    assign s_axi_bresp_o   = bresp_r;
    assign s_axi_arready_o = arready_r;
    assign s_axi_rvalid_o  = rvalid_r;
    assign s_axi_rdata_o   = rdata_r;
    assign s_axi_rresp_o   = rresp_r;
    assign dest_o          = dest_r;
    assign flags_o         = flags_r;

endmodule // bsfu_top

//--- logic/bsfu_map.svh
// named offsets, field positions and reset values of the bit, shift and flag unit
// assumes an 8-bit byte address on the register bus and one word per register
`ifndef BSFU_MAP_SVH
`define BSFU_MAP_SVH

// ----------
// register byte offsets
// ----------
`define BSFU_ADDR_DEST    8'h00
`define BSFU_ADDR_SRC     8'h04
`define BSFU_ADDR_FLAGS   8'h08
`define BSFU_ADDR_CMD     8'h0c
`define BSFU_ADDR_STAT    8'h10

// ----------
// status flag bit positions
// ----------
`define BSFU_FLAG_C       3'h0
`define BSFU_FLAG_Z       3'h1
`define BSFU_FLAG_N       3'h2
`define BSFU_FLAG_V       3'h3
`define BSFU_FLAG_S       3'h4
`define BSFU_FLAG_H       3'h5
`define BSFU_FLAG_T       3'h6
`define BSFU_FLAG_I       3'h7

// ----------
// command word fields and status word fields
// ----------
`define BSFU_CMD_OP_MSB   3'h4
`define BSFU_CMD_OP_LSB   3'h0
`define BSFU_CMD_IDX_MSB  3'h7
`define BSFU_CMD_IDX_LSB  3'h5
`define BSFU_STAT_BAD     4'h8

// ----------
// reset values and bus answers
// ----------
`define BSFU_RST_BYTE     8'h00
`define BSFU_RST_WORD     32'h0000_0000
`define BSFU_RESP_OKAY    2'h0
`define BSFU_RESP_SLVERR  2'h2
`define BSFU_BYTE_ZERO    8'h00
`define BSFU_CNT_STEP     8'h01

`endif

//--- logic/bsfu_pkg.sv
// types shared by the bit, shift and flag unit and its executor
// assumes nothing of its surroundings
package bsfu_pkg;

    typedef logic [7:0] bsfu_byte_t;
    typedef logic [2:0] bsfu_idx_t;
    typedef logic [1:0] bsfu_resp_t;

    // operation select; codes follow declaration order from zero
    typedef enum logic [4:0] {
        BSFU_OP_IDLE,
        BSFU_OP_ROTATE_LEFT_CARRY,
        BSFU_OP_ROTATE_RIGHT_CARRY,
        BSFU_OP_ARITH_SHIFT_RIGHT,
        BSFU_OP_NIBBLE_SWAP,
        BSFU_OP_STATUS_BIT_ON,
        BSFU_OP_STATUS_BIT_OFF,
        BSFU_OP_BIT_TO_TRANSFER_FLAG,
        BSFU_OP_TRANSFER_FLAG_TO_BIT,
        BSFU_OP_CARRY_ON,
        BSFU_OP_CARRY_OFF,
        BSFU_OP_NEGATIVE_ON,
        BSFU_OP_NEGATIVE_OFF,
        BSFU_OP_ZERO_ON,
        BSFU_OP_ZERO_OFF,
        BSFU_OP_IRQ_GLOBAL_ON,
        BSFU_OP_IRQ_GLOBAL_OFF,
        BSFU_OP_SIGNED_ON,
        BSFU_OP_SIGNED_OFF
    } bsfu_op_e;

endpackage

//--- logic/bsfu_exec.sv
// combinational executor: one operation on the working byte and the status flags
// assumes its caller registers the results at the clock edge that issues the op
`include "bsfu_map.svh"

module bsfu_exec (
    input  bsfu_pkg::bsfu_op_e  op_i,
    input  bsfu_pkg::bsfu_idx_t idx_i,
    input  bsfu_pkg::bsfu_byte_t dest_i,
    input  bsfu_pkg::bsfu_byte_t src_i,
    input  bsfu_pkg::bsfu_byte_t flags_i,
    output bsfu_pkg::bsfu_byte_t dest_o,
    output bsfu_pkg::bsfu_byte_t flags_o,
    output logic                 bad_o
);
    import bsfu_pkg::*;

    // shift results set z, c, n and v; v follows n xor c after the move
    function automatic bsfu_byte_t shift_flags(input bsfu_byte_t fl,
                                               input bsfu_byte_t res,
                                               input logic       cout);
        bsfu_byte_t f;
        f                 = fl;
        f[`BSFU_FLAG_Z]   = (res == `BSFU_BYTE_ZERO);
        f[`BSFU_FLAG_C]   = cout;
        f[`BSFU_FLAG_N]   = res[7];
        f[`BSFU_FLAG_V]   = res[7] ^ cout;
        return f;
    endfunction

    bsfu_byte_t asr_w;

    genvar n;
    generate
        for (n = 0; n < 7; n++) begin : g_asr
            assign asr_w[n] = dest_i[n+1];
        end
    endgenerate
    assign asr_w[7] = dest_i[7];

    always_comb begin
        dest_o  = dest_i;
        flags_o = flags_i;
        bad_o   = 1'b0;
        unique case (op_i)
            BSFU_OP_IDLE: begin
                dest_o = dest_i;
            end
            BSFU_OP_ROTATE_LEFT_CARRY: begin
                dest_o  = {dest_i[6:0], flags_i[`BSFU_FLAG_C]};
                flags_o = shift_flags(flags_i, {dest_i[6:0], flags_i[`BSFU_FLAG_C]}, dest_i[7]);
            end
            BSFU_OP_ROTATE_RIGHT_CARRY: begin
                dest_o  = {flags_i[`BSFU_FLAG_C], dest_i[7:1]};
                flags_o = shift_flags(flags_i, {flags_i[`BSFU_FLAG_C], dest_i[7:1]}, dest_i[0]);
            end
            BSFU_OP_ARITH_SHIFT_RIGHT: begin
                dest_o  = asr_w;
                flags_o = shift_flags(flags_i, asr_w, dest_i[0]);
            end
            BSFU_OP_NIBBLE_SWAP: begin
                dest_o = {dest_i[3:0], dest_i[7:4]};
            end
            BSFU_OP_STATUS_BIT_ON:  flags_o[idx_i] = 1'b1;
            BSFU_OP_STATUS_BIT_OFF: flags_o[idx_i] = 1'b0;
            BSFU_OP_BIT_TO_TRANSFER_FLAG: flags_o[`BSFU_FLAG_T] = src_i[idx_i];
            BSFU_OP_TRANSFER_FLAG_TO_BIT: dest_o[idx_i] = flags_i[`BSFU_FLAG_T];
            BSFU_OP_CARRY_ON:       flags_o[`BSFU_FLAG_C] = 1'b1;
            BSFU_OP_CARRY_OFF:      flags_o[`BSFU_FLAG_C] = 1'b0;
            BSFU_OP_NEGATIVE_ON:    flags_o[`BSFU_FLAG_N] = 1'b1;
            BSFU_OP_NEGATIVE_OFF:   flags_o[`BSFU_FLAG_N] = 1'b0;
            BSFU_OP_ZERO_ON:        flags_o[`BSFU_FLAG_Z] = 1'b1;
            BSFU_OP_ZERO_OFF:       flags_o[`BSFU_FLAG_Z] = 1'b0;
            BSFU_OP_IRQ_GLOBAL_ON:  flags_o[`BSFU_FLAG_I] = 1'b1;
            BSFU_OP_IRQ_GLOBAL_OFF: flags_o[`BSFU_FLAG_I] = 1'b0;
            BSFU_OP_SIGNED_ON:      flags_o[`BSFU_FLAG_S] = 1'b1;
            BSFU_OP_SIGNED_OFF:     flags_o[`BSFU_FLAG_S] = 1'b0;
            // unlisted codes leave everything alone and are reported
            default:                bad_o = 1'b1;
        endcase
    end

endmodule // bsfu_exec

//--- verification/bsfu_top_sva.sv
// assertion checker for the bit, shift and flag unit top
// assumes aligned byte addresses of at least eight bits
`include "bsfu_map.svh"
module bsfu_top_sva #(
    parameter int ADDR_W = 8
) (
    input logic                 clk_i,
    input logic                 arst_n_i,
    input logic [ADDR_W-1:0]    s_axi_awaddr_i,
    input logic                 s_axi_awvalid_i,
    input logic                 s_axi_awready_o,
    input logic [31:0]          s_axi_wdata_i,
    input logic [3:0]           s_axi_wstrb_i,
    input logic                 s_axi_wvalid_i,
    input logic                 s_axi_wready_o,
    input bsfu_pkg::bsfu_resp_t s_axi_bresp_o,
    input logic                 s_axi_bvalid_o,
    input logic                 s_axi_bready_i,
    input logic                 s_axi_arvalid_i,
    input logic                 s_axi_arready_o,
    input logic                 s_axi_rvalid_o,
    input bsfu_pkg::bsfu_byte_t dest_o,
    input bsfu_pkg::bsfu_byte_t flags_o
);
    import bsfu_pkg::*;
    logic       wh;
    logic       cw;
    logic       ok;
    logic [4:0] op;
    logic [2:0] fp;
    logic [7:0] m;
    logic [7:0] fm;
    logic [7:0] fx;
    logic [7:0] dx;
    // ----------
    // command decode seen at the bus
    // ----------
    // only writes with both channels taken in one edge are judged
    assign wh = s_axi_awvalid_i & s_axi_awready_o & s_axi_wvalid_i & s_axi_wready_o;
    assign cw = wh & s_axi_wstrb_i[0] & (s_axi_awaddr_i[7:0] == `BSFU_ADDR_CMD);
    assign op = s_axi_wdata_i[4:0];
    assign m  = 8'h01 << s_axi_wdata_i[7:5];
    assign fp = (op < 5'd11) ? `BSFU_FLAG_C : (op < 5'd13) ? `BSFU_FLAG_N :
                (op < 5'd15) ? `BSFU_FLAG_Z : (op < 5'd17) ? `BSFU_FLAG_I : `BSFU_FLAG_S;
    assign fm = 8'h01 << fp;
    assign fx = op[0] ? (flags_o | fm) : (flags_o & ~fm);
    assign dx = flags_o[`BSFU_FLAG_T] ? (dest_o | m) : (dest_o & ~m);
    assign ok = (flags_o[1] == (dest_o == 8'h00)) & (flags_o[2] == dest_o[7])
              & (flags_o[3] == (dest_o[7] ^ flags_o[0]));
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!arst_n_i);
    wr_answer_a: assert property (wh |=> s_axi_bvalid_o)
        else $error("write response missing");
    rd_answer_a: assert property (s_axi_arvalid_i & s_axi_arready_o
        |=> s_axi_rvalid_o & !s_axi_arready_o) else $error("read answer missing");
    bresp_hold_a: assert property (s_axi_bvalid_o & !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o)) else $error("write response dropped");
    rot_left_a: assert property (cw && op == 5'd1 |=> ok && flags_o[0] == $past(dest_o[7])
        && dest_o == {$past(dest_o[6:0]), $past(flags_o[0])}) else $error("rotate left wrong");
    rot_right_a: assert property (cw && op == 5'd2 |=> ok && flags_o[0] == $past(dest_o[0])
        && dest_o == {$past(flags_o[0]), $past(dest_o[7:1])}) else $error("rotate right wrong");
    arith_shift_a: assert property (cw && op == 5'd3 |=> ok && flags_o[0] == $past(dest_o[0])
        && dest_o == {$past(dest_o[7]), $past(dest_o[7:1])}) else $error("shift wrong");
    nib_swap_a: assert property (cw && op == 5'd4 |=> $stable(flags_o)
        && dest_o == {$past(dest_o[3:0]), $past(dest_o[7:4])}) else $error("swap wrong");
    bit_on_a: assert property (cw && op == 5'd5 |=> $stable(dest_o)
        && flags_o == ($past(flags_o) | $past(m))) else $error("flag set wrong");
    bit_off_a: assert property (cw && op == 5'd6 |=> $stable(dest_o)
        && flags_o == ($past(flags_o) & ~$past(m))) else $error("flag clear wrong");
    tstore_keep_a: assert property (cw && op == 5'd7 |=> $stable(dest_o)
        && (flags_o & 8'hbf) == $past(flags_o & 8'hbf)) else $error("transfer store wrong");
    tload_a: assert property (cw && op == 5'd8 |=> $stable(flags_o)
        && dest_o == $past(dx)) else $error("transfer load wrong");
    flag_op_a: assert property (cw && op inside {[5'd9:5'd18]}
        |=> flags_o == $past(fx) && $stable(dest_o)) else $error("single flag op wrong");
endmodule // bsfu_top_sva

bind bsfu_top bsfu_top_sva #(.ADDR_W(ADDR_W)) bsfu_top_sva_inst (
    .clk_i, .arst_n_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o,
    .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o,
    .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
    .s_axi_arready_o, .s_axi_rvalid_o, .dest_o, .flags_o
);

//--- verification/bsfu_core_model.sv
// core-side model: issues register accesses and commands as a bus master
// assumes the caller starts each task right after a rising clock edge
`include "bsfu_map.svh"
module bsfu_core_model (
    input  logic                 clk_i,
    output logic [7:0]           awaddr_o,
    output logic                 awvalid_o,
    input  logic                 awready_i,
    output logic [31:0]          wdata_o,
    output logic [3:0]           wstrb_o,
    output logic                 wvalid_o,
    input  logic                 wready_i,
    input  bsfu_pkg::bsfu_resp_t bresp_i,
    input  logic                 bvalid_i,
    output logic                 bready_o,
    output logic [7:0]           araddr_o,
    output logic                 arvalid_o,
    input  logic                 arready_i,
    input  logic [31:0]          rdata_i,
    input  bsfu_pkg::bsfu_resp_t rresp_i,
    input  logic                 rvalid_i,
    output logic                 rready_o,
    output logic                 hung_o
);
    import bsfu_pkg::*;
    initial begin
        {awaddr_o, awvalid_o, wdata_o, wstrb_o, wvalid_o, bready_o} = '0;
        {araddr_o, arvalid_o, rready_o, hung_o} = '0;
    end
    // a wait that runs out raises hung_o instead of blocking forever
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      output bsfu_resp_t r);
        int n;
        @(posedge clk_i);
        awaddr_o <= a;
        wdata_o <= d;
        wstrb_o <= s;
        awvalid_o <= 1'b1;
        wvalid_o <= 1'b1;
        bready_o <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_i);
            if (awready_i) awvalid_o <= 1'b0;
            if (wready_i) wvalid_o <= 1'b0;
            if (bvalid_i) break;
        end
        r = bresp_i;
        bready_o <= 1'b0;
        if (n == 64) hung_o <= 1'b1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output bsfu_resp_t r);
        int n;
        @(posedge clk_i);
        araddr_o <= a;
        arvalid_o <= 1'b1;
        rready_o <= 1'b1;
        for (n = 0; n < 64; n++) begin
            @(posedge clk_i);
            if (arready_i) arvalid_o <= 1'b0;
            if (rvalid_i) break;
        end
        d = rdata_i;
        r = rresp_i;
        rready_o <= 1'b0;
        if (n == 64) hung_o <= 1'b1;
    endtask
    task automatic issue(input logic [4:0] op, input logic [2:0] ix, output bsfu_resp_t r);
        wr(`BSFU_ADDR_CMD, {24'h0, ix, op}, 4'hf, r);
    endtask
endmodule // bsfu_core_model

//--- verification/bit_shift_flag_unit_tb.sv
// self-checking bench: core model drives the unit over its register bus
// assumes the unit answers every access within a few cycles
`include "bsfu_map.svh"
module bit_shift_flag_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import bsfu_pkg::*;
    localparam logic [2:0] FPOS [5] = '{3'h0, 3'h2, 3'h1, 3'h7, 3'h4};
    logic clk, arst_n, awv, awr, wv, wr, bv, br, arv, arr, rv, rr, hung;
    logic [7:0] awa, ara;
    logic [31:0] wd, rdat, rdv;
    logic [3:0] ws;
    bsfu_resp_t bresp, rresp, resp;
    bsfu_byte_t dest, flags, md, ms, mf, cnt;
    logic bad;
    int fail_count, checks;
    bsfu_top bsfu_top_inst (.clk_i(clk), .arst_n_i(arst_n), .s_axi_awaddr_i(awa),
        .s_axi_awprot_i(3'h0), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
        .s_axi_wdata_i(wd), .s_axi_wstrb_i(ws), .s_axi_wvalid_i(wv), .s_axi_wready_o(wr),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(br),
        .s_axi_araddr_i(ara), .s_axi_arprot_i(3'h0), .s_axi_arvalid_i(arv),
        .s_axi_arready_o(arr), .s_axi_rdata_o(rdat), .s_axi_rresp_o(rresp),
        .s_axi_rvalid_o(rv), .s_axi_rready_i(rr), .dest_o(dest), .flags_o(flags));
    bsfu_core_model bsfu_core_model_inst (.clk_i(clk), .awaddr_o(awa), .awvalid_o(awv),
        .awready_i(awr), .wdata_o(wd), .wstrb_o(ws), .wvalid_o(wv), .wready_i(wr),
        .bresp_i(bresp), .bvalid_i(bv), .bready_o(br), .araddr_o(ara), .arvalid_o(arv),
        .arready_i(arr), .rdata_i(rdat), .rresp_i(rresp), .rvalid_i(rv), .rready_o(rr),
        .hung_o(hung));
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge hung) begin
        fail_count++;
        results();
    end
    task automatic model(input logic [4:0] op, input logic [2:0] i);
        logic c;
        c = mf[0];
        case (op)
            5'd1: begin c = md[7]; md = {md[6:0], mf[0]}; end
            5'd2: begin c = md[0]; md = {mf[0], md[7:1]}; end
            5'd3: begin c = md[0]; md = {md[7], md[7:1]}; end
            5'd4: md = {md[3:0], md[7:4]};
            5'd5: mf[i] = 1'b1;
            5'd6: mf[i] = 1'b0;
            5'd7: mf[6] = ms[i];
            5'd8: md[i] = mf[6];
            default: if (op > 5'd8 && op < 5'd19) mf[FPOS[(op - 5'd9) >> 1]] = op[0];
        endcase
        if (op > 5'd0 && op < 5'd4) mf[3:0] = {md[7] ^ c, md[7], md == 8'h00, c};
    endtask
    task automatic exe(input logic [4:0] op, input logic [2:0] i);
        bsfu_core_model_inst.issue(op, i, resp);
        model(op, i);
        cnt++;
        bad = op > 5'd18;
        chk("cmd resp", 32'(resp), 32'h0);
        chk("dest", 32'(dest), 32'(md));
        chk("flags", 32'(flags), 32'(mf));
    endtask
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial begin
        {arst_n, cnt, bad, fail_count, checks} = '0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        for (int a = 0; a < 6; a++) begin
            bsfu_core_model_inst.rd(8'(a * 4), rdv, resp);
            chk("reset read", rdv, 32'h0);
            chk("read resp", 32'(resp), (a == 5) ? 32'h2 : 32'h0);
        end
        bsfu_core_model_inst.wr(8'h14, 32'h1, 4'hf, resp);
        chk("unmapped write", 32'(resp), 32'h2);
        ms = 8'h5a;
        bsfu_core_model_inst.wr(`BSFU_ADDR_SRC, 32'(ms), 4'hf, resp);
        for (int p = 0; p < 2; p++) begin
            md = p ? 8'h01 : 8'h96;
            mf = p ? 8'hff : 8'h00;
            bsfu_core_model_inst.wr(`BSFU_ADDR_DEST, 32'(md), 4'hf, resp);
            bsfu_core_model_inst.wr(`BSFU_ADDR_FLAGS, 32'(mf), 4'hf, resp);
            for (int o = 1; o < 19; o++) exe(5'(o), 3'(o) ^ {3{p[0]}});
        end
        // a command without its byte lane must do nothing
        bsfu_core_model_inst.wr(`BSFU_ADDR_CMD, 32'h4, 4'h0, resp);
        chk("strobe off", {resp, dest}, {2'h0, md});
        exe(5'h13, 3'h0);
        bsfu_core_model_inst.rd(`BSFU_ADDR_STAT, rdv, resp);
        chk("stat", rdv, {23'h0, bad, cnt});
        exe(5'h0, 3'h0);
        bsfu_core_model_inst.rd(`BSFU_ADDR_STAT, rdv, resp);
        chk("stat", rdv, {23'h0, bad, cnt});
        bsfu_core_model_inst.rd(`BSFU_ADDR_DEST, rdv, resp);
        chk("dest read", rdv, 32'(md));
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        chk("reset state", {dest, flags}, 16'h0);
        results();
    end
endmodule // bit_shift_flag_unit_tb
